// ===== rtl/lcdh_top.sv
// Host register access, address pointer and display scan of the LCD controller
// ****************************************************************
// ****************************************************************
`timescale 1ns/100ps
module lcdh_top
#(
    parameter int RESET_HOLD_CYC = lcdh_pkg::RST_HOLD_CYC
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       host_enable,
    input  wire logic       register_select,
    input  wire logic       read_write,
    input  wire logic [7:0] db_in,
    output logic      [7:0] db_out,
    output logic            db_oe,
    input  wire logic       reset_pin_n,
    output logic            busy_indicator,
    output logic      [1:0] pix_line,
    output logic      [3:0] pix_pos,
    output logic      [2:0] pix_row,
    output logic            pix_user,
    output logic      [7:0] pix_rom_index,
    output logic      [4:0] pix_dots
);
    import lcdh_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    localparam int PIN_W = 12;
    // Reset pin idles high, so no false low follows reset
    localparam logic [PIN_W-1:0] PIN_IDLE = {1'b1, 11'h000};
    logic [PIN_W-1:0] pin_s1_q;
    logic [PIN_W-1:0] pin_s2_q;
    logic [PIN_W-1:0] pin_s3_q;
    logic [PIN_W-1:0] pin_q;
    logic             en_prev_q;
    logic             acc_d;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_q <= PIN_IDLE;
            pin_s2_q <= PIN_IDLE;
            pin_s3_q <= PIN_IDLE;
        end else begin
            pin_s1_q <= {reset_pin_n, host_enable, register_select, read_write, db_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Each pin counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_pin
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pin_q[gi] <= (gi == PIN_W - 1);
                end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
                    pin_q[gi] <= pin_s3_q[gi];
                end
            end
        end
    endgenerate

    logic       rst_pin_n_f;
    logic       en_f;
    logic       rs_f;
    logic       rw_f;
    logic [7:0] db_f;
    assign {rst_pin_n_f, en_f, rs_f, rw_f, db_f} = pin_q;

    // Access is taken on the falling enable
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            en_prev_q <= 1'b0;
        end else begin
            en_prev_q <= en_f;
        end
    end
    assign acc_d = en_prev_q && !en_f;

    // ****************************************************************
    // Long reset pin detection
    // ****************************************************************
    logic [CNT_W-1:0] rst_cnt_q;
    logic             srst_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_cnt_q <= '0;
            srst_q    <= 1'b0;
        end else if (rst_pin_n_f) begin
            rst_cnt_q <= '0;
            srst_q    <= 1'b0;
        end else if (rst_cnt_q < CNT_W'(RESET_HOLD_CYC)) begin
            rst_cnt_q <= rst_cnt_q + 1'b1;
        end else begin
            srst_q    <= 1'b1;
        end
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    logic        idle;
    logic        ins_wr;
    logic        dat_wr;
    logic        dat_rd;
    lcdh_state_t state_q;

    assign idle   = (state_q == LCDH_ST_IDLE);
    assign ins_wr = acc_d && !rs_f && !rw_f && idle;
    assign dat_wr = acc_d &&  rs_f && !rw_f && idle;
    assign dat_rd = acc_d &&  rs_f &&  rw_f;

    logic        is_clear;
    logic        is_text;
    logic        is_glyph;
    logic        is_shift;
    logic        is_entry;
    logic        is_home;
    assign is_text  = db_f[BIT_TEXTSET];
    assign is_glyph = !is_text && db_f[BIT_GLYSET];
    assign is_shift = db_f[7:5] == 3'b000 && db_f[BIT_SHIFT];
    assign is_entry = db_f[7:3] == 5'b00000 && db_f[BIT_ENTRY];
    assign is_home  = db_f[7:2] == 6'b000000 && db_f[BIT_HOME];
    assign is_clear = db_f == INS_CLEAR;

    // ****************************************************************
    // Busy sequencing
    // ****************************************************************
    logic [12:0] exec_cnt_q;
    logic [5:0]  clr_addr_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q    <= LCDH_ST_IDLE;
            exec_cnt_q <= '0;
            clr_addr_q <= '0;
        end else if (srst_q) begin
            state_q    <= LCDH_ST_IDLE;
            exec_cnt_q <= '0;
            clr_addr_q <= '0;
        end else begin
            unique case (state_q)
                LCDH_ST_IDLE: begin
                    exec_cnt_q <= 13'(EXEC_CYC - 1);
                    clr_addr_q <= '0;
                    if (ins_wr) begin
                        state_q <= is_clear ? LCDH_ST_CLEAR : LCDH_ST_EXEC;
                    end
                end
                LCDH_ST_CLEAR: begin
                    clr_addr_q <= clr_addr_q + 1'b1;
                    if (clr_addr_q == 6'(TEXT_DEPTH - 1)) begin
                        state_q <= LCDH_ST_EXEC;
                    end
                end
                LCDH_ST_EXEC: begin
                    exec_cnt_q <= exec_cnt_q - 1'b1;
                    if (exec_cnt_q == '0) begin
                        state_q <= LCDH_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Address pointer, memory select, direction and shift
    // ****************************************************************
    logic [6:0] address_pointer_q;
    lcdh_mem_t  sel_q;
    logic       dir_up_q;
    logic [3:0] shift_q;
    logic [6:0] step_d;

    // Glyph memory wraps in its own 5-bit space
    always_comb begin
        step_d = dir_up_q ? address_pointer_q + 1'b1 : address_pointer_q - 1'b1;
        if (sel_q == LCDH_MEM_GLYPH) begin
            step_d = {2'b00, step_d[4:0]};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            address_pointer_q <= '0;
            sel_q             <= LCDH_MEM_TEXT;
            dir_up_q          <= 1'b1;
            shift_q           <= '0;
        end else if (srst_q) begin
            address_pointer_q <= '0;
            sel_q             <= LCDH_MEM_TEXT;
            dir_up_q          <= 1'b1;
            shift_q           <= '0;
        end else if (ins_wr) begin
            if (is_text) begin
                address_pointer_q <= db_f[6:0];
                sel_q <= (db_f[6:5] == ICON_BASE) ? LCDH_MEM_ICON : LCDH_MEM_TEXT;
            end else if (is_glyph) begin
                address_pointer_q <= {2'b00, db_f[4:0]};
                sel_q             <= LCDH_MEM_GLYPH;
            end else if (is_shift) begin
                if (db_f[FLD_SC]) begin
                    shift_q <= db_f[FLD_RL] ? shift_q - 1'b1 : shift_q + 1'b1;
                end else begin
                    address_pointer_q <= db_f[FLD_RL] ? address_pointer_q + 1'b1
                                                      : address_pointer_q - 1'b1;
                end
            end else if (is_entry) begin
                dir_up_q <= db_f[FLD_DIR];
            end else if (is_home || is_clear) begin
                address_pointer_q <= '0;
                sel_q             <= LCDH_MEM_TEXT;
                shift_q           <= '0;
                if (is_clear) begin
                    dir_up_q <= 1'b1;
                end
            end
        end else if (dat_wr || dat_rd) begin
            address_pointer_q <= step_d;
        end
    end

    // ****************************************************************
    // Data staging register and prefetch
    // ****************************************************************
    logic [7:0] data_staging_register_q;
    logic [1:0] fetch_q;
    logic       load_fetch;
    lcdh_mem_if mif ();

    // Pointer settles one edge, memory answers the next
    assign load_fetch = (ins_wr && (is_text || is_glyph)) || dat_rd;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fetch_q <= '0;
        end else if (srst_q) begin
            fetch_q <= '0;
        end else begin
            fetch_q <= {fetch_q[0], load_fetch};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            data_staging_register_q <= '0;
        end else if (srst_q) begin
            data_staging_register_q <= '0;
        end else if (dat_wr) begin
            data_staging_register_q <= db_f;
        end else if (fetch_q[1]) begin
            data_staging_register_q <= mif.rdata;
        end
    end

    // Clear fills text memory through the host port
    always_comb begin
        mif.we    = dat_wr;
        mif.sel   = sel_q;
        mif.addr  = address_pointer_q;
        mif.wdata = db_f;
        if (state_q == LCDH_ST_CLEAR) begin
            mif.we    = 1'b1;
            mif.sel   = LCDH_MEM_TEXT;
            mif.addr  = {1'b0, clr_addr_q};
            mif.wdata = BLANK_CODE;
        end
    end

    lcdh_mem u_mem (
        .mclk (mclk),
        .mif  (mif.mem)
    );

    // ****************************************************************
    // Host read path
    // ****************************************************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            db_out         <= '0;
            db_oe          <= 1'b0;
            busy_indicator <= 1'b0;
        end else begin
            busy_indicator <= !idle;
            db_oe          <= en_f && rw_f && !srst_q;
            // Instruction register reads give busy and the address pointer
            if (rs_f) begin
                db_out <= data_staging_register_q;
            end else begin
                db_out <= {!idle, address_pointer_q};
            end
        end
    end

    // ****************************************************************
    // Display scan
    // ****************************************************************
    logic [1:0] sc_line_q;
    logic [3:0] sc_pos_q;
    logic [2:0] sc_row_q;
    logic [8:0] p1_q;
    logic [8:0] p2_q;
    logic [7:0] p2_code_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sc_line_q <= '0;
            sc_pos_q  <= '0;
            sc_row_q  <= '0;
        end else if (sc_pos_q != 4'hF) begin
            sc_pos_q <= sc_pos_q + 1'b1;
        end else begin
            sc_pos_q <= '0;
            if (sc_row_q != 3'(GLYPH_ROWS - 1)) begin
                sc_row_q <= sc_row_q + 1'b1;
            end else begin
                sc_row_q  <= '0;
                sc_line_q <= (sc_line_q == 2'(LINES - 1)) ? 2'b00 : sc_line_q + 1'b1;
            end
        end
    end

    // Line number stays the high bits, so wrap stays in line
    assign mif.text_saddr = {sc_line_q, 4'(sc_pos_q + shift_q)};
    assign mif.glyph_saddr = {mif.text_sdata[1:0], p1_q[2:0]};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            p1_q      <= '0;
            p2_q      <= '0;
            p2_code_q <= '0;
        end else begin
            p1_q      <= {sc_line_q, sc_pos_q, sc_row_q};
            p2_q      <= p1_q;
            p2_code_q <= mif.text_sdata;
        end
    end

    // Fixed pattern ROM sits outside; index 0 is code 04h
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pix_line      <= '0;
            pix_pos       <= '0;
            pix_row       <= '0;
            pix_user      <= 1'b0;
            pix_rom_index <= '0;
            pix_dots      <= '0;
        end else begin
            {pix_line, pix_pos, pix_row} <= p2_q;
            pix_user      <= p2_code_q[7:2] == 6'h00;
            pix_rom_index <= (p2_code_q[7:2] == 6'h00) ? 8'h00
                                                       : p2_code_q - ROM_FIRST;
            pix_dots      <= (p2_code_q[7:2] == 6'h00) ? mif.glyph_sdata : 5'h00;
        end
    end
endmodule

// ===== rtl/lcdh_pkg.sv
// Package of constants and types for the LCD host register access block
package lcdh_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 8;
    localparam int EXEC_TIME_NS   = 30000;
    localparam int EXEC_CYC       = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_HOLD_NS    = 1200000;
    localparam int RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 18;

    // ****************************************************************
    // Memory geometry
    // ****************************************************************
    localparam int      TEXT_DEPTH  = 48;
    localparam int      GLYPH_DEPTH = 32;
    localparam int      ICON_DEPTH  = 32;
    localparam int      DOT_W       = 5;
    localparam int      LINES       = 3;
    localparam int      GLYPH_ROWS  = 7;
    localparam logic [6:0] TEXT_LAST = 7'h2F;
    localparam logic [1:0] ICON_BASE = 2'b11;
    localparam logic [7:0] BLANK_CODE = 8'h20;
    localparam logic [7:0] ROM_FIRST = 8'h04;

    // ****************************************************************
    // Instruction codes and field positions
    // ****************************************************************
    localparam logic [7:0] INS_CLEAR   = 8'h01;
    localparam int         BIT_TEXTSET = 7;
    localparam int         BIT_GLYSET  = 6;
    localparam int         BIT_SHIFT   = 4;
    localparam int         BIT_ENTRY   = 2;
    localparam int         BIT_HOME    = 1;
    localparam int         FLD_DIR     = 1;
    localparam int         FLD_SC      = 3;
    localparam int         FLD_RL      = 2;
    localparam int         BIT_BUSY    = 7;

    typedef enum logic [1:0] {
        LCDH_MEM_TEXT,
        LCDH_MEM_GLYPH,
        LCDH_MEM_ICON
    } lcdh_mem_t;

    typedef enum logic [1:0] {
        LCDH_ST_IDLE,
        LCDH_ST_CLEAR,
        LCDH_ST_EXEC
    } lcdh_state_t;
endpackage

// ===== rtl/lcdh_mem_if.sv
// Interface between control logic and the memory module
`timescale 1ns/100ps
interface lcdh_mem_if;
    import lcdh_pkg::*;
    logic            we;
    lcdh_mem_t       sel;
    logic [6:0]      addr;
    logic [7:0]      wdata;
    logic [7:0]      rdata;
    logic [5:0]      text_saddr;
    logic [7:0]      text_sdata;
    logic [4:0]      glyph_saddr;
    logic [4:0]      glyph_sdata;
    modport ctl (output we, sel, addr, wdata, text_saddr, glyph_saddr,
                 input rdata, text_sdata, glyph_sdata);
    modport mem (input we, sel, addr, wdata, text_saddr, glyph_saddr,
                 output rdata, text_sdata, glyph_sdata);
endinterface

// ===== rtl/lcdh_mem.sv
// Text, user glyph and icon memories with registered read data
`timescale 1ns/100ps
module lcdh_mem (
    input wire logic mclk,
    lcdh_mem_if.mem  mif
);
    import lcdh_pkg::*;

    logic [7:0]       text_q  [TEXT_DEPTH];
    logic [DOT_W-1:0] glyph_q [GLYPH_DEPTH];
    logic [DOT_W-1:0] icon_q  [ICON_DEPTH];
    logic             text_ok;

    assign text_ok = (mif.addr <= TEXT_LAST);

    // ****************************************************************
    // Host port
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (mif.we) begin
            unique case (mif.sel)
                LCDH_MEM_TEXT:  if (text_ok) text_q[mif.addr[5:0]] <= mif.wdata;
                LCDH_MEM_GLYPH: glyph_q[mif.addr[4:0]] <= mif.wdata[DOT_W-1:0];
                LCDH_MEM_ICON:  icon_q[mif.addr[4:0]] <= mif.wdata[DOT_W-1:0];
                default: ;
            endcase
        end
    end

    // Out of range text reads give zero
    always_ff @(posedge mclk) begin
        unique case (mif.sel)
            LCDH_MEM_TEXT:  mif.rdata <= text_ok ? text_q[mif.addr[5:0]] : 8'h00;
            LCDH_MEM_GLYPH: mif.rdata <= {3'h0, glyph_q[mif.addr[4:0]]};
            LCDH_MEM_ICON:  mif.rdata <= {3'h0, icon_q[mif.addr[4:0]]};
            default:        mif.rdata <= 8'h00;
        endcase
    end

    // ****************************************************************
    // Scan port
    // ****************************************************************
    always_ff @(posedge mclk) begin
        mif.text_sdata  <= text_q[mif.text_saddr];
        mif.glyph_sdata <= glyph_q[mif.glyph_saddr];
    end
endmodule

// ===== tb/lcdh_top_sva.sv
// Checker of the host port, busy timing and scan outputs
`timescale 1ns/100ps
module lcdh_top_sva
    import lcdh_pkg::*;
#(
    parameter int RESET_HOLD_CYC = 20
) (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       host_enable,
    input wire logic       register_select,
    input wire logic       read_write,
    input wire logic       reset_pin_n,
    input wire logic       db_oe,
    input wire logic       busy_indicator,
    input wire logic [1:0] pix_line,
    input wire logic [2:0] pix_row,
    input wire logic       pix_user,
    input wire logic [7:0] pix_rom_index,
    input wire logic [4:0] pix_dots
);
    // ****************************************************************
    // Cycle counters
    // ****************************************************************
    logic [CNT_W-1:0] busy_cnt_q;
    logic [CNT_W-1:0] pin_cnt_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= busy_indicator ? busy_cnt_q + 1'b1 : '0;
        end
    end
    // Runs are short, so no saturation is needed
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_cnt_q <= '0;
        end else begin
            pin_cnt_q <= reset_pin_n ? '0 : pin_cnt_q + 1'b1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    oe_rise_a: assert property ($rose(db_oe) |-> host_enable && read_write)
        else $error("bus driven without a read strobe");
    oe_drop_a: assert property (!host_enable [*6] |-> !db_oe)
        else $error("bus still driven after strobe ended");
    busy_cause_a: assert property ($rose(busy_indicator) |-> !register_select && !read_write)
        else $error("busy raised without an instruction write");
    busy_min_a: assert property ($fell(busy_indicator) |-> int'(busy_cnt_q) >= EXEC_CYC)
        else $error("busy ended too early");
    busy_max_a: assert property (busy_indicator |-> int'(busy_cnt_q) <= EXEC_CYC + 50)
        else $error("busy lasted too long");
    line_range_a: assert property (pix_line <= 2'h2)
        else $error("scan line out of range");
    row_range_a: assert property (pix_row <= 3'h6)
        else $error("scan row out of range");
    user_dots_a: assert property (!pix_user |-> pix_dots == 5'h00)
        else $error("user dots shown for a fixed code");
    user_index_a: assert property (pix_user |-> pix_rom_index == 8'h00)
        else $error("table index set for a user code");
    reset_quiet_a: assert property ($rose(nrst) |-> !busy_indicator && !db_oe)
        else $error("outputs active right after reset");
    soft_reset_a: assert property (int'(pin_cnt_q) > RESET_HOLD_CYC + 8 |-> !db_oe)
        else $error("bus driven during pin reset");
    cover property ($fell(busy_indicator));
    cover property ($rose(db_oe) && register_select);
    cover property (int'(pin_cnt_q) == RESET_HOLD_CYC + 10);
endmodule

// ===== tb/lcdh_host.sv
// Host processor model for the parallel register port
`timescale 1ns/100ps
module lcdh_host (
    input  wire logic       mclk,
    input  wire logic       busy_indicator,
    input  wire logic [7:0] db_out,
    output logic            host_enable,
    output logic            register_select,
    output logic            read_write,
    output logic      [7:0] db_in
);
    logic [7:0] rd_q;
    initial begin
        host_enable = 1'b0;
        register_select = 1'b0;
        read_write = 1'b1;
        db_in = 8'hA5;
    end
    // Levels lead the strobe by 2 edges and stay 8 edges after it so the synchroniser sees them settle
    task automatic access(input logic rs, input logic rw, input logic [7:0] d);
        @(posedge mclk);
        register_select <= rs;
        read_write <= rw;
        db_in <= d;
        repeat (2) @(posedge mclk);
        host_enable <= 1'b1;
        repeat (8) @(posedge mclk);
        rd_q = db_out;
        host_enable <= 1'b0;
        repeat (8) @(posedge mclk);
        db_in <= ~d;
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 5000 && busy_indicator !== 1'b0; i++) begin
            @(posedge mclk);
        end
    endtask
    task automatic write(input logic rs, input logic [7:0] d);
        wait_ready();
        access(rs, 1'b0, d);
    endtask
endmodule

// ===== tb/lcd_host_register_access_tb.sv
// Self-checking bench of the LCD host register access block
`timescale 1ns/100ps
module lcd_host_register_access_tb;
    import lcdh_pkg::*;
    localparam int         HOLD = 20;
    localparam logic [7:0] MA [5] = '{8'h82, 8'h42, 8'hE2, 8'hAF, 8'hB0};
    localparam logic [7:0] MW [5] = '{8'h11, 8'h0A, 8'h17, 8'h66, 8'h55};
    localparam logic [7:0] MR [5] = '{8'h11, 8'h0A, 8'h17, 8'h66, 8'h00};
    logic       mclk, nrst, reset_pin_n, host_enable, register_select, read_write;
    logic       db_oe, busy_indicator, pix_user;
    logic [7:0] db_in, db_out, pix_rom_index;
    logic [1:0] pix_line;
    logic [3:0] pix_pos;
    logic [2:0] pix_row;
    logic [4:0] pix_dots;
    int         errors;
    int         checked;
    lcdh_top #(.RESET_HOLD_CYC(HOLD)) DUT (
        .mclk(mclk), .nrst(nrst), .host_enable(host_enable),
        .register_select(register_select), .read_write(read_write), .db_in(db_in),
        .db_out(db_out), .db_oe(db_oe), .reset_pin_n(reset_pin_n),
        .busy_indicator(busy_indicator), .pix_line(pix_line), .pix_pos(pix_pos),
        .pix_row(pix_row), .pix_user(pix_user), .pix_rom_index(pix_rom_index),
        .pix_dots(pix_dots)
    );
    lcdh_host host (
        .mclk(mclk), .busy_indicator(busy_indicator), .db_out(db_out),
        .host_enable(host_enable), .register_select(register_select),
        .read_write(read_write), .db_in(db_in)
    );
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic status(input logic [7:0] exp);
        host.access(1'b0, 1'b1, ~db_in);
        chk(host.rd_q, exp);
    endtask
    task automatic dread(input logic [7:0] exp);
        host.access(1'b1, 1'b1, ~db_in);
        chk(host.rd_q, exp);
    endtask
    // Waits for one scan position; gives up after more than a full frame
    task automatic scan(input logic [1:0] l, input logic [3:0] p, input logic [2:0] r,
                        input logic u, input logic [7:0] idx, input logic [4:0] dots);
        int n;
        n = 0;
        @(posedge mclk);
        while ((pix_line !== l || pix_pos !== p || pix_row !== r) && n < 400) begin
            @(posedge mclk);
            n++;
        end
        chk({pix_user, pix_row, pix_pos}, {u, r, p});
        chk({pix_line, 1'b0, pix_dots}, {l, 1'b0, dots});
        chk(pix_rom_index, idx);
    endtask
    task automatic pin_low(input int n);
        @(posedge mclk);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge mclk);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_access();
        status(8'h00);
        host.write(1'b0, 8'h85);
        host.wait_ready();
        status(8'h05);
        host.write(1'b1, 8'hA5);
        host.write(1'b1, 8'h3C);
        status(8'h07);
        host.write(1'b0, 8'h85);
        host.wait_ready();
        dread(8'hA5);
        dread(8'h3C);
        status(8'h07);
        $display("Test access done");
    endtask
    task automatic t_busy();
        host.write(1'b0, 8'h8A);
        status(8'h8A);
        host.access(1'b1, 1'b0, 8'h77);
        host.wait_ready();
        status(8'h0A);
        $display("Test busy done");
    endtask
    task automatic t_mems();
        for (int i = 0; i < 5; i++) begin
            host.write(1'b0, MA[i]);
            host.write(1'b1, MW[i]);
        end
        for (int i = 0; i < 5; i++) begin
            host.write(1'b0, MA[i]);
            host.wait_ready();
            dread(MR[i]);
        end
        $display("Test memories done");
    endtask
    task automatic t_dir();
        host.write(1'b0, 8'h04);
        host.write(1'b0, 8'h90);
        host.write(1'b1, 8'h42);
        status(8'h0F);
        host.write(1'b0, 8'h90);
        host.wait_ready();
        dread(8'h42);
        status(8'h0F);
        $display("Test direction done");
    endtask
    // Runs after the direction test, so the pointer steps down
    task automatic t_scan();
        host.write(1'b0, 8'hA1);
        host.write(1'b1, 8'h00);
        host.write(1'b1, 8'h00);
        scan(2'h0, 4'h5, 3'h2, 1'b0, 8'hA1, 5'h00);
        scan(2'h2, 4'hF, 3'h2, 1'b0, 8'h62, 5'h00);
        host.write(1'b0, 8'h18);
        scan(2'h0, 4'h4, 3'h3, 1'b0, 8'hA1, 5'h00);
        scan(2'h2, 4'hF, 3'h2, 1'b1, 8'h00, 5'h0A);
        $display("Test scan done");
    endtask
    task automatic t_pin();
        host.write(1'b0, 8'h83);
        host.wait_ready();
        pin_low(HOLD - 8);
        status(8'h03);
        host.write(1'b0, 8'h06);
        host.wait_ready();
        pin_low(HOLD + 12);
        host.wait_ready();
        status(8'h00);
        $display("Test reset pin done");
    endtask
    initial begin
        errors = 0;
        checked = 0;
        nrst = 1'b0;
        reset_pin_n = 1'b1;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        t_access();
        t_busy();
        t_mems();
        t_dir();
        t_scan();
        t_pin();
        test_done();
    end
    // Bound covers roughly 25 instruction executions
    initial begin
        repeat (95000) @(posedge mclk);
        errors++;
        test_done();
    end
endmodule

bind lcdh_top lcdh_top_sva #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) u_sva (
    .mclk(mclk), .nrst(nrst), .host_enable(host_enable),
    .register_select(register_select), .read_write(read_write),
    .reset_pin_n(reset_pin_n), .db_oe(db_oe), .busy_indicator(busy_indicator),
    .pix_line(pix_line), .pix_row(pix_row), .pix_user(pix_user),
    .pix_rom_index(pix_rom_index), .pix_dots(pix_dots)
);
